// ### sps_port.sv
// Byte-wide serial peripheral port with status, data and control registers
// Functional notes
// - Bit order select 0 shifts MSB first, 1 shifts LSB first.
// - Controller serial clock is system clock over 2, 4, 8 or 16.
// - Transfer done flag, status bit 7, sets when each transfer completes.
// - Transfer done clears on interrupt vectoring or software writing 0.
// - Write collision, bit 6, sets on data write while busy.
// - Write collision clears on writing 0 or data rewrite when not busy.
// - Controller with select enabled: select low sets mode fault, bit 5.
// - Mode fault setting clears port enable and controller mode bits.
// - Overrun, bit 4, sets when transfer ends with receive full set.
// - Receive full, bit 3, sets each transfer end; cleared by 0 or read.
// - Read-only busy, bit 2, high only while a transfer runs.
// - Controller data write loads shift register and starts a transfer.
// - Data read returns receive buffer, not the shift register.
// - Port inactive while port enable is 0.
// - Serial clock idles at clock polarity level.
// - Phase 0 samples on first edge, phase 1 on second edge.
// - Select pin used when select disable is 0, ignored when 1.
`timescale 1ns/1ps
module sps_port
    import sps_pkg::*;
(
    input wire logic ref_clk, // 40 MHz system clock
    input wire logic arst_n, // Async reset, active low
    input wire logic [7:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic irq_vector, // Interrupt vectored acknowledge pulse
    output logic irq, // Level interrupt
    input wire logic sclk_in, // Serial clock from pin
    output logic sclk_out, // Serial clock drive
    output logic sclk_oe_n, // Serial clock enable, low drives
    input wire logic mosi_in, // Controller out pin level
    output logic mosi_out, // Controller out drive
    output logic mosi_oe_n, // Controller out enable, low drives
    input wire logic miso_in, // Peripheral out pin level
    output logic miso_out, // Peripheral out drive
    output logic miso_oe_n, // Peripheral out enable, low drives
    input wire logic sel_n // Slave-select pin, active low
);
    typedef struct packed {
        sps_state_type st;
        logic [7:0] ctl;
        logic [7:0] sta;
        logic [7:0] mask;
        logic [7:0] rxbuf;
        logic [7:0] shreg;
        logic [3:0] bitcnt;
        logic sample;
        logic sclk_prev;
        logic sclk;
        logic mosi;
        logic miso;
        logic sclk_oe_n;
        logic mosi_oe_n;
        logic miso_oe_n;
        logic [7:0] rdata;
        logic irq;
    } sps_state_reg_type;

    sps_state_reg_type s_r, s_nxt;
    logic half_tick;
    logic en, ctrl, cpol, cpha, bit_order_select, sel_used;
    logic busy, leading, trailing, out_bit, in_bit;
    logic done, sel_fault;
    logic wr_ctl, wr_sta, wr_dat, wr_msk, rd_dat;

    assign en = s_r.ctl[SPS_CTL_PORT_EN];
    assign ctrl = s_r.ctl[SPS_CTL_CONTROLLER];
    assign cpol = s_r.ctl[SPS_CTL_CPOL];
    assign cpha = s_r.ctl[SPS_CTL_CPHA];
    assign bit_order_select = s_r.ctl[SPS_CTL_BIT_ORDER];
    assign sel_used = !s_r.ctl[SPS_CTL_SEL_DIS];
    assign busy = (s_r.st != SPS_IDLE);

    sps_clk_div u_div (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .run(busy && ctrl),
        .rate_sel(s_r.ctl[SPS_CTL_RATE_LO +: 2]),
        .half_tick(half_tick)
    );

    always_comb begin
        wr_ctl = 1'b0;
        wr_sta = 1'b0;
        wr_dat = 1'b0;
        wr_msk = 1'b0;
        rd_dat = 1'b0;
        if (reg_addr == SPS_ADDR_CONTROL) begin
            wr_ctl = reg_wr;
        end else if (reg_addr == SPS_ADDR_STATUS) begin
            wr_sta = reg_wr;
        end else if (reg_addr == SPS_ADDR_DATA) begin
            wr_dat = reg_wr;
            rd_dat = reg_rd;
        end else if (reg_addr == SPS_ADDR_IRQ_MASK) begin
            wr_msk = reg_wr;
        end
    end

    // Serial clock edges: controller uses divider, peripheral watches the pin
    always_comb begin
        if (ctrl) begin
            leading = half_tick && s_r.st == SPS_LEAD;
            trailing = half_tick && s_r.st == SPS_TRAIL;
        end else begin
            leading = (sclk_in != s_r.sclk_prev) && (sclk_in != cpol);
            trailing = (sclk_in != s_r.sclk_prev) && (sclk_in == cpol);
        end
        out_bit = bit_order_select ? s_r.shreg[0] : s_r.shreg[7];
        in_bit = ctrl ? miso_in : mosi_in;
    end

    assign sel_fault = en && ctrl && sel_used && !sel_n;

    always_comb begin
        s_nxt = s_r;
        done = 1'b0;
        s_nxt.sclk_prev = sclk_in;
        // Transfer engine
        case (s_r.st)
            SPS_IDLE: begin
                s_nxt.bitcnt = 4'h0;
                if (en && ctrl && wr_dat) begin
                    s_nxt.shreg = reg_wdata;
                    s_nxt.st = SPS_LEAD;
                end else if (en && !ctrl && !(sel_used && sel_n) && !cpha && leading) begin
                    // Phase 0 peripheral: first edge already samples
                    s_nxt.sample = in_bit;
                    s_nxt.st = SPS_TRAIL;
                end else if (en && !ctrl && !(sel_used && sel_n) && cpha && leading) begin
                    s_nxt.st = SPS_TRAIL;
                end
            end
            SPS_LEAD: begin
                if (leading) begin
                    if (!cpha) begin
                        s_nxt.sample = in_bit;
                    end
                    s_nxt.st = SPS_TRAIL;
                end
            end
            SPS_TRAIL: begin
                if (trailing) begin
                    s_nxt.shreg = bit_order_select ? {cpha ? in_bit : s_r.sample, s_r.shreg[7:1]}
                        : {s_r.shreg[6:0], cpha ? in_bit : s_r.sample};
                    s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                    s_nxt.st = SPS_LEAD;
                    if (s_r.bitcnt == SPS_BITS_PER_BYTE - 4'h1) begin
                        s_nxt.st = SPS_IDLE;
                        done = 1'b1;
                    end
                end
            end
            default: s_nxt.st = SPS_IDLE;
        endcase
        // Peripheral whose select rises mid-byte abandons the byte
        if (!en || (!ctrl && sel_used && sel_n && busy)) begin
            s_nxt.st = SPS_IDLE;
        end
        if (done) begin
            s_nxt.rxbuf = s_nxt.shreg;
        end
        // Pins: serial clock toggles per half period, idles at polarity
        s_nxt.sclk_oe_n = !(en && ctrl);
        s_nxt.mosi_oe_n = !(en && ctrl);
        s_nxt.miso_oe_n = !(en && !ctrl && !(sel_used && sel_n));
        if (s_nxt.st == SPS_IDLE) begin
            s_nxt.sclk = cpol;
        end else if (leading || trailing) begin
            s_nxt.sclk = !s_r.sclk;
        end
        // Phase 1 shifts out on leading edge, phase 0 presents before it
        if ((cpha && leading) || (!cpha && (s_nxt.st == SPS_LEAD || s_r.st == SPS_IDLE))) begin
            s_nxt.mosi = bit_order_select ? s_nxt.shreg[0] : s_nxt.shreg[7];
            s_nxt.miso = bit_order_select ? s_nxt.shreg[0] : s_nxt.shreg[7];
        end else if (!cpha && trailing) begin
            s_nxt.mosi = out_bit;
            s_nxt.miso = out_bit;
        end
        // Registers written by software; hardware sets win below
        if (wr_ctl) begin
            s_nxt.ctl = reg_wdata;
        end
        if (wr_msk) begin
            s_nxt.mask = reg_wdata;
        end
        if (wr_sta) begin
            for (int i = SPS_ST_FULL; i <= SPS_ST_DONE; i++) begin
                if (!reg_wdata[i]) begin
                    s_nxt.sta[i] = 1'b0;
                end
            end
        end
        if (irq_vector) begin
            s_nxt.sta[SPS_ST_DONE] = 1'b0;
        end
        if (wr_dat && !busy) begin
            s_nxt.sta[SPS_ST_WRITE_COLLISION_FLAG] = 1'b0;
        end
        if (rd_dat) begin
            s_nxt.sta[SPS_ST_OVR] = 1'b0;
            s_nxt.sta[SPS_ST_FULL] = 1'b0;
        end
        if (wr_dat && busy) begin
            s_nxt.sta[SPS_ST_WRITE_COLLISION_FLAG] = 1'b1;
        end
        if (done) begin
            s_nxt.sta[SPS_ST_DONE] = 1'b1;
            s_nxt.sta[SPS_ST_FULL] = 1'b1;
            if (s_r.sta[SPS_ST_FULL]) begin
                s_nxt.sta[SPS_ST_OVR] = 1'b1;
            end
        end
        if (sel_fault) begin
            s_nxt.sta[SPS_ST_MODE_FAULT_FLAG] = 1'b1;
            s_nxt.ctl[SPS_CTL_PORT_EN] = 1'b0;
            s_nxt.ctl[SPS_CTL_CONTROLLER] = 1'b0;
            s_nxt.st = SPS_IDLE;
        end
        s_nxt.sta[SPS_ST_BUSY] = (s_nxt.st != SPS_IDLE);
        s_nxt.sta[1:0] = 2'h0;
        // Read data
        s_nxt.rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == SPS_ADDR_CONTROL) begin
                s_nxt.rdata = s_r.ctl;
            end else if (reg_addr == SPS_ADDR_STATUS) begin
                s_nxt.rdata = s_r.sta;
            end else if (reg_addr == SPS_ADDR_DATA) begin
                s_nxt.rdata = s_r.rxbuf;
            end else if (reg_addr == SPS_ADDR_IRQ_MASK) begin
                s_nxt.rdata = s_r.mask;
            end
        end
        s_nxt.irq = |(s_nxt.sta & s_nxt.mask & SPS_ST_EVENT_MASK);
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
            s_r.st <= SPS_IDLE;
            s_r.ctl <= SPS_CONTROL_RST;
            s_r.sta <= SPS_STATUS_RST;
            s_r.mask <= SPS_MASK_RST;
            s_r.rxbuf <= SPS_DATA_RST;
            s_r.sclk_oe_n <= 1'b1;
            s_r.mosi_oe_n <= 1'b1;
            s_r.miso_oe_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign irq = s_r.irq;
    assign sclk_out = s_r.sclk;
    assign sclk_oe_n = s_r.sclk_oe_n;
    assign mosi_out = s_r.mosi;
    assign mosi_oe_n = s_r.mosi_oe_n;
    assign miso_out = s_r.miso;
    assign miso_oe_n = s_r.miso_oe_n;

    chk_fault_drops_enable: assert property (@(posedge ref_clk) disable iff (!arst_n)
        sel_fault |=> !s_r.ctl[SPS_CTL_PORT_EN] && s_r.sta[SPS_ST_MODE_FAULT_FLAG])
        else $error("mode fault did not drop enable");
    chk_write_collision_flag_on_busy: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (wr_dat && busy) |=> s_r.sta[SPS_ST_WRITE_COLLISION_FLAG])
        else $error("write collision not flagged");
    chk_done_sets_flags: assert property (@(posedge ref_clk) disable iff (!arst_n)
        done |=> s_r.sta[SPS_ST_DONE] && s_r.sta[SPS_ST_FULL] && !s_r.sta[SPS_ST_BUSY])
        else $error("transfer end flags missing");
    chk_overrun_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (done && s_r.sta[SPS_ST_FULL]) |=> s_r.sta[SPS_ST_OVR])
        else $error("overrun not flagged");
    chk_read_clears_full: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (rd_dat && !done) |=> !s_r.sta[SPS_ST_FULL] && reg_rdata == $past(s_r.rxbuf))
        else $error("data read did not clear full");
    chk_busy_tracks: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_r.sta[SPS_ST_BUSY] == busy)
        else $error("busy flag mismatch");
    chk_start_on_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (en && ctrl && !busy && wr_dat && !sel_fault) |=> busy && s_r.shreg == $past(reg_wdata))
        else $error("write did not start transfer");
    chk_idle_clock_level: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!busy && $past(!busy)) |-> sclk_out == $past(cpol))
        else $error("serial clock not at idle level");
    chk_vector_clears: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (irq_vector && !done) |=> !s_r.sta[SPS_ST_DONE])
        else $error("vectoring did not clear done");
    chk_write_collision_flag_rewrite: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (wr_dat && !busy) |=> !s_r.sta[SPS_ST_WRITE_COLLISION_FLAG])
        else $error("write collision not cleared");
    chk_disabled_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !en |=> !busy && s_r.sclk_oe_n)
        else $error("disabled port still active");
endmodule

// ### sps_pkg.sv
// Package for the serial peripheral port: offsets, fields, reset values
package sps_pkg;
    // Register byte addresses on the special function register port
    localparam logic [7:0] SPS_ADDR_CONTROL = 8'hbc;
    localparam logic [7:0] SPS_ADDR_STATUS = 8'hbd;
    localparam logic [7:0] SPS_ADDR_DATA = 8'hbe;
    localparam logic [7:0] SPS_ADDR_IRQ_MASK = 8'hbf;
    // Control register fields
    localparam int SPS_CTL_PORT_EN = 7;
    localparam int SPS_CTL_CONTROLLER = 6;
    localparam int SPS_CTL_CPOL = 5;
    localparam int SPS_CTL_CPHA = 4;
    localparam int SPS_CTL_SEL_DIS = 3;
    localparam int SPS_CTL_BIT_ORDER = 2;
    localparam int SPS_CTL_RATE_LO = 0;
    // Status register fields
    localparam int SPS_ST_DONE = 7;
    localparam int SPS_ST_WRITE_COLLISION_FLAG = 6;
    localparam int SPS_ST_MODE_FAULT_FLAG = 5;
    localparam int SPS_ST_OVR = 4;
    localparam int SPS_ST_FULL = 3;
    localparam int SPS_ST_BUSY = 2;
    // Status bits that raise the interrupt
    localparam logic [7:0] SPS_ST_EVENT_MASK = 8'hf8;
    // Reset values
    localparam logic [7:0] SPS_CONTROL_RST = 8'h00;
    localparam logic [7:0] SPS_STATUS_RST = 8'h00;
    localparam logic [7:0] SPS_DATA_RST = 8'h00;
    localparam logic [7:0] SPS_MASK_RST = 8'h00;
    // Bits per transfer
    localparam logic [3:0] SPS_BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        SPS_IDLE = 3'b001,
        SPS_LEAD = 3'b010,
        SPS_TRAIL = 3'b100
    } sps_state_type;
endpackage

// ### sps_clk_div.sv
// Serial clock rate divider producing a one-cycle half-period enable
`timescale 1ns/1ps
module sps_clk_div
    import sps_pkg::*;
(
    input wire logic ref_clk, // System clock
    input wire logic arst_n, // Async reset, active low
    input wire logic run, // Count while high, restart when low
    input wire logic [1:0] rate_sel, // Clock rate select
    output logic half_tick // One-cycle pulse each half serial period
);
    typedef struct packed {
        logic [2:0] cnt;
        logic tick;
    } sps_div_type;

    sps_div_type s_r, s_nxt;
    logic [2:0] half_limit;

    // Full period is 2,4,8,16 system clocks so half is 1,2,4,8
    always_comb begin
        half_limit = 3'((4'h1 << rate_sel) - 4'h1);
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (!run) begin
            s_nxt.cnt = 3'h0;
        end else if (s_r.cnt >= half_limit) begin
            s_nxt.cnt = 3'h0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 3'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign half_tick = s_r.tick;
endmodule

// ### sps_peer_model.sv
// Behavioural serial peer answering the port in controller mode
`timescale 1ns/1ps
module sps_peer_model (
    input wire logic sclk, // Serial clock on the wire
    input wire logic mosi, // Data from the controller
    input wire logic cpol, // Idle clock level
    input wire logic cpha, // Sample on second edge when high
    input wire logic lsb_first, // Bit order
    input wire logic active, // Byte frame open
    input wire logic [7:0] tx_byte, // Byte to return
    output logic miso, // Data to the controller
    output logic [7:0] rx_byte // Byte received
);
    int smp;
    int sft;
    int idx;
    always @(posedge active) begin
        smp = 0;
        sft = 0;
    end
    always @(sclk) begin
        if (active && ((sclk != cpol) ^ cpha)) begin
            rx_byte[lsb_first ? smp : 7 - smp] = mosi;
            smp = smp + 1;
        end else if (active) begin
            sft = sft + 1;
        end
    end
    always_comb begin
        idx = cpha ? sft - 1 : sft;
        if (active && idx >= 0 && idx < 8) begin
            miso = tx_byte[lsb_first ? idx : 7 - idx];
        end else begin
            // Outside the byte no stale bit is left on the line
            miso = sft[0];
        end
    end
endmodule

// ### sps_port_bench.sv
// Self-checking bench for the serial peripheral port
`timescale 1ns/1ps
module sps_port_bench;
    import sps_pkg::*;
    localparam logic [7:0] AC = SPS_ADDR_CONTROL;
    localparam logic [7:0] AS = SPS_ADDR_STATUS;
    localparam logic [7:0] AD = SPS_ADDR_DATA;
    localparam logic [7:0] AM = SPS_ADDR_IRQ_MASK;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic irq_vector = 1'b0;
    logic sel_n = 1'b0;
    logic cpol = 1'b0;
    logic cpha = 1'b0;
    logic bit_order_select = 1'b0;
    logic active = 1'b0;
    logic [7:0] peer_tx = 8'h00;
    logic ext_sclk = 1'b0;
    logic ext_mosi = 1'b0;
    logic [7:0] pd;
    logic [7:0] reg_rdata, peer_rx;
    logic irq, sclk_out, sclk_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, peer_miso;
    logic [7:0] addrs [5] = '{AC, AS, AD, AM, 8'hc0};
    int errors = 0;
    int checked = 0;
    int n;
    wire sclk_w = sclk_oe_n ? ext_sclk : sclk_out;
    wire mosi_w = mosi_oe_n ? ext_mosi : mosi_out;
    wire miso_w = miso_oe_n ? peer_miso : miso_out;

    always #12.5 ref_clk = ~ref_clk;

    sps_port DUT (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_vector(irq_vector), .irq(irq),
        .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .mosi_in(mosi_w),
        .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_w), .miso_out(miso_out),
        .miso_oe_n(miso_oe_n), .sel_n(sel_n));

    sps_peer_model peer (.sclk(sclk_w), .mosi(mosi_w), .cpol(cpol), .cpha(cpha), .lsb_first(bit_order_select),
        .active(active), .tx_byte(peer_tx), .miso(peer_miso), .rx_byte(peer_rx));

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    task automatic vector_pulse;
        @(posedge ref_clk);
        irq_vector <= 1'b1;
        @(posedge ref_clk);
        irq_vector <= 1'b0;
    endtask

    // Bounded so a lost completion cannot hang the run
    task automatic wait_irq(output int c);
        c = 0;
        while (irq !== 1'b1 && c < 1000) begin
            @(posedge ref_clk);
            #1 c++;
        end
    endtask

    // External controller for peripheral mode: phase 0, MSB first, caller holds select low
    task automatic ext_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int b = 7; b >= 0; b--) begin
            @(posedge ref_clk);
            ext_mosi <= tx[b];
            repeat (2) @(posedge ref_clk);
            #1 rx[b] = miso_w;
            @(posedge ref_clk);
            ext_sclk <= 1'b1;
            repeat (3) @(posedge ref_clk);
            ext_sclk <= 1'b0;
        end
    endtask

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        wr(8'hc0, 8'hff);
        foreach (addrs[k]) rchk(addrs[k], 8'h00);
        $display("test reset values done");
        wr(AM, 8'h80);
        // Select held low: only the disable bit keeps the fault away
        for (int i = 0; i < 4; i++) begin
            cpol <= i[1];
            cpha <= i[0];
            bit_order_select <= i[1] ^ i[0];
            peer_tx <= 8'h3c + 8'(i * 37);
            wr(AC, {2'b11, i[1], i[0], 1'b1, i[1] ^ i[0], i[1:0]});
            // Polarity change moves the idle clock; the peer must not count it as an edge
            repeat (2) @(posedge ref_clk);
            active <= 1'b1;
            wr(AD, 8'hc5 - 8'(i));
            rchk(AS, 8'h04);
            wait_irq(n);
            active <= 1'b0;
            chk({7'h00, n >= (16 << i) - 2 && n <= (16 << i) + 3}, 8'h01);
            chk(peer_rx, 8'hc5 - 8'(i));
            chk({7'h00, sclk_out}, {7'h00, i[1]});
            rchk(AS, 8'h88);
            rchk(AD, 8'h3c + 8'(i * 37));
            rchk(AS, 8'h80);
            if (i == 0) begin
                wr(AM, 8'h00);
                @(posedge ref_clk);
                #1 chk({7'h00, irq}, 8'h00);
                wr(AM, 8'h80);
            end
            if (i[0]) vector_pulse();
            else wr(AS, 8'h00);
            rchk(AS, 8'h00);
            chk({7'h00, irq}, 8'h00);
        end
        $display("test transfer modes done");
        cpol <= 1'b0;
        cpha <= 1'b0;
        bit_order_select <= 1'b0;
        peer_tx <= 8'h5a;
        wr(AC, 8'hc8);
        repeat (2) @(posedge ref_clk);
        active <= 1'b1;
        wr(AD, 8'ha1);
        wr(AD, 8'h7e);
        wait_irq(n);
        active <= 1'b0;
        chk(peer_rx, 8'ha1);
        rchk(AS, 8'hc8);
        vector_pulse();
        peer_tx <= 8'h96;
        active <= 1'b1;
        wr(AD, 8'h3b);
        wait_irq(n);
        active <= 1'b0;
        rchk(AS, 8'h98);
        rchk(AD, 8'h96);
        rchk(AS, 8'h80);
        wr(AS, 8'h00);
        $display("test collision and overrun done");
        wr(AC, 8'h48);
        wr(AD, 8'h11);
        repeat (40) @(posedge ref_clk);
        rchk(AS, 8'h00);
        chk({7'h00, sclk_oe_n}, 8'h01);
        $display("test disabled port done");
        wr(AC, 8'hc0);
        repeat (4) @(posedge ref_clk);
        rchk(AS, 8'h20);
        rchk(AC, 8'h00);
        sel_n <= 1'b1;
        wr(AS, 8'h00);
        rchk(AS, 8'h00);
        $display("test mode fault done");
        // Peripheral cannot be loaded, so it sends back what the shift register last held
        wr(AC, 8'h80);
        sel_n <= 1'b0;
        ext_byte(8'h69, pd);
        repeat (2) @(posedge ref_clk);
        chk(pd, 8'h96);
        chk({6'h00, miso_oe_n, mosi_oe_n}, 8'h01);
        rchk(AS, 8'h88);
        chk({7'h00, irq}, 8'h01);
        rchk(AD, 8'h69);
        $display("test peripheral mode done");
        complete_run();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        complete_run();
    end
endmodule
